// file: tb/cbc_ctrl_sva.sv
// Checker for the broadcast decision, bound to cbc_ctrl.
// Assumes cfg_i held static between resets.
`default_nettype none
module cbc_ctrl_sva (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic clk_en_i,
   input wire cbc_pkg::cbc_cfg_t cfg_i,
   input wire cbc_pkg::cbc_txn_t txn_i,
   input wire logic bcast_o,
   input wire logic txn_valid_o,
   input wire logic cfg_ready_o,
   input wire logic cfg_error_o
);
   wire logic t = clk_en_i & cfg_ready_o & txn_i.valid;
   wire logic [1:0] d = txn_i.domain;
   wire logic [2:0] c = cfg_i;
   wire logic m = |txn_i.op;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);
   AST_IN: assert property (t&&c[2]&&d==1 |=> bcast_o) else $error("in");
   AST_OUT: assert property (t&&c[1]&&d==2 |=> bcast_o) else $error("o");
   AST_MNT: assert property (t&&c[0]&&m |=> bcast_o) else $error("m");
   AST_DOM: assert property (t&&!c[0]&&d[0]==d[1] |=> !bcast_o)
      else $error("dom");
   AST_NONE: assert property (t&&c==0 |=> !bcast_o) else $error("n");
   AST_PROM: assert property (t&&c==4&&d==2 |=> bcast_o) else $error("p");
   AST_ERR: assert property (cfg_ready_o |-> cfg_error_o==(c[2]&!c[1]))
      else $error("err");
   AST_VLD: assert property (clk_en_i |=> txn_valid_o==$past(t))
      else $error("vld");
   cover property (t ##1 bcast_o);
   cover property (cfg_error_o);
   cover property (!clk_en_i && txn_valid_o);
endmodule : cbc_ctrl_sva
bind cbc_ctrl cbc_ctrl_sva u_sva (.*);
`default_nettype wire

// file: tb/cbc_icn_model.sv
// Interconnect stand-in: counts the snoops it is told to send.
// Assumes the decision is qualified by the valid output.
`default_nettype none
module cbc_icn_model (
   input wire logic sys_clk_i,
   input wire logic en_i,
   input wire logic bcast_i,
   output int snoops_o
);
   initial snoops_o = 0;
   always @(posedge sys_clk_i) if (en_i && bcast_i) snoops_o++;
endmodule : cbc_icn_model
`default_nettype wire

// file: tb/coherent_broadcast_control_test.sv
// Bench: every control setting against every transaction kind.
// Assumes the package and design are compiled first.
`default_nettype none
`define CHK(n, e, s) n_checks++; if ((s) !== (e)) begin failures++; \
   $display("wrong value %s exp %h got %h", n, e, s); end
module coherent_broadcast_control_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk_i = 0, rstn_i = 0, clk_en_i = 1, e;
   logic bcast_o, txn_valid_o, cfg_ready_o, cfg_error_o;
   cbc_pkg::cbc_cfg_t cfg_i = '0;
   cbc_pkg::cbc_txn_t txn_i = '0;
   int failures = 0, n_checks = 0, snoops;
   initial forever #10 sys_clk_i = ~sys_clk_i;
   cbc_ctrl dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .clk_en_i(clk_en_i),
      .cfg_i(cfg_i), .txn_i(txn_i), .bcast_o(bcast_o),
      .txn_valid_o(txn_valid_o), .cfg_ready_o(cfg_ready_o),
      .cfg_error_o(cfg_error_o));
   cbc_icn_model icn (.sys_clk_i(sys_clk_i), .en_i(txn_valid_o & clk_en_i),
      .bcast_i(bcast_o), .snoops_o(snoops));
   task automatic boot(input logic [2:0] c);
      rstn_i = 0;
      cfg_i = c;
      // Valid traffic while the controls settle must be refused
      txn_i = 5'h1f;
      repeat (5) @(negedge sys_clk_i);
      rstn_i = 1;
      repeat (3) @(negedge sys_clk_i);
      `CHK("ready", 1'h1, cfg_ready_o)
      `CHK("early", 1'h0, txn_valid_o)
      `CHK("error", c[2] & ~c[1], cfg_error_o)
   endtask : boot
   task automatic t_table;
      int base;
      int n_e;
      base = snoops;
      n_e = 0;
      for (int k = 0; k < 8; k++) begin
         boot(k[2:0]);
         for (int i = 0; i < 16; i++) begin
            txn_i = {1'h1, i[3:0]};
            e = (k[2] && i[3:2] == 1) || (k[1] | k[2]) && i[3:2] == 2;
            e = e || (k[0] && i[1:0] != 0);
            @(negedge sys_clk_i);
            `CHK("bcast", e, bcast_o)
            `CHK("valid", 1'h1, txn_valid_o)
            n_e = n_e + e;
         end
         // Let the model count the last decision before reset hits
         txn_i = '0;
         @(negedge sys_clk_i);
      end
      `CHK("snoops", n_e, snoops - base)
      $display("t_table done");
   endtask : t_table
   task automatic t_hold;
      int base;
      boot(3'h3);
      base = snoops;
      txn_i = 5'h18;
      @(negedge sys_clk_i);
      clk_en_i = 0;
      txn_i = '0;
      repeat (3) @(negedge sys_clk_i);
      `CHK("frozen", 1'h1, bcast_o)
      `CHK("held", 1'h1, txn_valid_o)
      clk_en_i = 1;
      @(negedge sys_clk_i);
      `CHK("idle", 1'h0, txn_valid_o)
      `CHK("one snoop", 1, snoops - base)
      $display("t_hold done");
   endtask : t_hold
   task automatic end_of_test;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_of_test
   initial begin
      t_table();
      t_hold();
      end_of_test();
   end
   // Tests need about 4.3 us; more than ten times that is a hang
   initial begin
      #50us;
      failures++;
      end_of_test();
   end
endmodule : coherent_broadcast_control_test
`default_nettype wire

// file: verilog/cbc_ctrl.sv
// Broadcast decision for coherent transactions from static controls.
// Assumes controls come from tie-offs or another domain; they are
// synchronised and then latched once as the working configuration.
// Outputs come straight from flip-flops; decisions lag by one cycle.
`default_nettype none
module cbc_ctrl (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic clk_en_i,
   input wire cbc_pkg::cbc_cfg_t cfg_i,
   input wire cbc_pkg::cbc_txn_t txn_i,
   output logic bcast_o,
   output logic txn_valid_o,
   output logic cfg_ready_o,
   output logic cfg_error_o
);
   // Stage one of the control synchroniser; only stage two reads it
   cbc_pkg::cbc_cfg_t sync1_ff;
   cbc_pkg::cbc_cfg_t sync2_ff;

   // Working configuration, written once after each reset
   cbc_pkg::cbc_cfg_t cfg_ff;
   cbc_pkg::cbc_cfg_t nxt_cfg;
   logic [1:0] cnt_ff;
   logic cnt_at_end;
   logic cfg_ready_ff;
   logic cfg_error_ff;
   logic nxt_cfg_error;
   logic latch_now;

   // Per-transaction decision path
   logic txn_take;
   logic dom_hit;
   logic maint_hit;
   logic nxt_bcast;
   logic nxt_txn_valid;
   logic bcast_ff;
   logic txn_valid_ff;

   // Clean-shared, clean-invalid and make-invalid form the class
   function automatic logic is_maint(input cbc_pkg::cbc_op_t op);
      is_maint = 1'b0;
      unique case (op)
         cbc_pkg::CBC_OP_OTHER: begin
            is_maint = 1'b0;
         end
         cbc_pkg::CBC_OP_CLEAN_SHARED: begin
            is_maint = 1'b1;
         end
         cbc_pkg::CBC_OP_CLEAN_INVALID: begin
            is_maint = 1'b1;
         end
         cbc_pkg::CBC_OP_MAKE_INVALID: begin
            is_maint = 1'b1;
         end
      endcase
   endfunction : is_maint

   // Domain gate, shared by ordinary and maintenance transactions
   function automatic logic dom_enabled(
      input cbc_pkg::cbc_cfg_t cfg,
      input cbc_pkg::cbc_domain_t dom
   );
      dom_enabled = 1'b0;
      unique case (dom)
         cbc_pkg::CBC_DOM_NONSHARE: begin
            dom_enabled = 1'b0;
         end
         cbc_pkg::CBC_DOM_INNER: begin
            dom_enabled = cfg.bcast_inner_domain_en;
         end
         cbc_pkg::CBC_DOM_OUTER: begin
            dom_enabled = cfg.bcast_outer_domain_en;
         end
         // System scope is never enabled by this gate; only an enabled maintenance op broadcasts it
         cbc_pkg::CBC_DOM_SYSTEM: begin
            dom_enabled = 1'b0;
         end
      endcase
   endfunction : dom_enabled

   // Inner without outer is illegal; widening it loses no snoops
   function automatic cbc_pkg::cbc_cfg_t promote_cfg(
      input cbc_pkg::cbc_cfg_t cfg
   );
      cbc_pkg::cbc_cfg_t fixed;
      fixed = cfg;
      fixed.bcast_outer_domain_en = cfg.bcast_outer_domain_en
         | cfg.bcast_inner_domain_en;
      promote_cfg = fixed;
   endfunction : promote_cfg

   function automatic logic cfg_illegal(input cbc_pkg::cbc_cfg_t cfg);
      cfg_illegal = 1'b0;
      if (cfg.bcast_inner_domain_en && !cfg.bcast_outer_domain_en) begin
         cfg_illegal = 1'b1;
      end
   endfunction : cfg_illegal

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync1_ff <= '0;
      end else if (clk_en_i) begin
         sync1_ff <= cfg_i;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync2_ff <= '0;
      end else if (clk_en_i) begin
         sync2_ff <= sync1_ff;
      end
   end

   always_comb begin
      cnt_at_end = (cnt_ff == cbc_pkg::CBC_SYNC_LAST);
   end

   // Stage two holds the sampled pins by the time the counter ends
   always_comb begin
      latch_now = 1'b0;
      if (clk_en_i && !cfg_ready_ff) begin
         latch_now = cnt_at_end;
      end
   end

   always_comb begin
      nxt_cfg = promote_cfg(sync2_ff);
   end

   always_comb begin
      nxt_cfg_error = cfg_illegal(sync2_ff);
   end

   // Counter parks at its end value until the next reset
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_ff <= '0;
      end else if (clk_en_i && !cfg_ready_ff && !latch_now) begin
         cnt_ff <= cnt_ff + 2'h1;
      end
   end

   // Once set, later changes on the control pins are ignored
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cfg_ready_ff <= cbc_pkg::CBC_CFG_RST;
      end else if (latch_now) begin
         cfg_ready_ff <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cfg_ff <= '0;
      end else if (latch_now) begin
         cfg_ff <= nxt_cfg;
      end
   end

   // Error flag stays until reset, like the configuration itself
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cfg_error_ff <= cbc_pkg::CBC_CFG_RST;
      end else if (latch_now) begin
         cfg_error_ff <= nxt_cfg_error;
      end
   end

   // Nothing is taken before the configuration is latched
   always_comb begin
      txn_take = txn_i.valid & cfg_ready_ff;
   end

   // Maintenance with its control low still passes through this gate
   always_comb begin
      dom_hit = dom_enabled(cfg_ff, txn_i.domain);
   end

   always_comb begin
      maint_hit = 1'b0;
      if (cfg_ff.bcast_maint_ops_en) begin
         maint_hit = is_maint(txn_i.op);
      end
   end

   // Broadcast is the union of the enabled classes
   always_comb begin
      nxt_bcast = 1'b0;
      if (txn_take) begin
         nxt_bcast = dom_hit | maint_hit;
      end
   end

   always_comb begin
      nxt_txn_valid = txn_take;
   end

   // Registered decision, held while clk_en_i is low
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         bcast_ff <= 1'b0;
      end else if (clk_en_i) begin
         bcast_ff <= nxt_bcast;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         txn_valid_ff <= 1'b0;
      end else if (clk_en_i) begin
         txn_valid_ff <= nxt_txn_valid;
      end
   end

   assign bcast_o = bcast_ff;
   assign txn_valid_o = txn_valid_ff;
   assign cfg_ready_o = cfg_ready_ff;
   assign cfg_error_o = cfg_error_ff;
endmodule : cbc_ctrl
`default_nettype wire

// file: verilog/cbc_pkg.sv
// Constants and carrier types for the coherent broadcast control block.
// Assumes a single 50 MHz clock domain and static configuration levels.
`default_nettype none
package cbc_pkg;
   typedef enum logic [1:0] {
      CBC_DOM_NONSHARE,
      CBC_DOM_INNER,
      CBC_DOM_OUTER,
      CBC_DOM_SYSTEM
   } cbc_domain_t;

   typedef enum logic [1:0] {
      CBC_OP_OTHER,
      CBC_OP_CLEAN_SHARED,
      CBC_OP_CLEAN_INVALID,
      CBC_OP_MAKE_INVALID
   } cbc_op_t;

   typedef struct packed {
      logic bcast_inner_domain_en;
      logic bcast_outer_domain_en;
      logic bcast_maint_ops_en;
   } cbc_cfg_t;

   typedef struct packed {
      logic valid;
      cbc_domain_t domain;
      cbc_op_t op;
   } cbc_txn_t;

   localparam logic CBC_CFG_RST = 1'h0;
   localparam logic [1:0] CBC_SYNC_LAST = 2'h2;
endpackage : cbc_pkg
`default_nettype wire
